//--- lpms_sequencer.sv
// Operating-mode sequencer: active, standby, stop, watch, subactive
// Assumes synchronous mode strobes from the CPU core and interrupt logic
// What this block does
// - Five modes; subactive enabled by build option
// - Active mode runs everything on main oscillator
// - Standby instruction in active enters standby
// - Standby and watch hold ports and state
// - Standby exits on reset or any interrupt
// - Wake services interrupt only if enabled
// - Stop with watch select clear halts main
// - Subclock stop bit halts sub oscillator in stop
// - Stop exits on reset or stop cancel pin
// - Stop resets peripherals, ports high impedance
// - RAM intact after stop, registers not
// - Watch entered by stop or subactive instruction
// - Watch runs only timer A and LCD
// - Watch stops serial and raises no serial interrupt
// - Watch wake goes active or subactive by flag
// - Watch wake delay per interrupt source
// - Subactive entered from watch; main oscillator off
// - Subactive direct transfer instruction goes active
// - Direct flag accepted only in subactive
// - Cancel pin ignored outside stop; RAM flag
// - Instruction is no-op with pending disabled interrupt
// - Subactive runs all but converter and tone on subclock
`timescale 1ns/10ps
`include "lpms_regs.svh"
module lpms_sequencer
  import lpms_pkg::*;
#(
  parameter bit SUBACTIVE_EN = 1'b1,
  parameter int STAB_CYCLES = `LPMS_STAB_CYCLES,
  parameter int FRAME_CYCLES = `LPMS_FRAME_CYCLES
)
(
  input wire logic core_clk_i,
  input wire logic reset_i,
  input wire logic standby_instruction_i,
  input wire logic stop_instruction_i,
  input wire logic watch_select_bit_i,
  input wire logic subclock_stop_bit_i,
  input wire logic low_speed_flag_i,
  input wire logic direct_transfer_set_i,
  input wire logic global_interrupt_enable_i,
  input wire logic irq_pending_i,
  input wire logic timer_a_irq_i,
  input wire logic external_interrupt_zero_i,
  input wire logic stop_cancel_pin_i,
  output lpms_mode_t mode_o,
  output lpms_gate_t gate_o,
  output lpms_clk_t clk_ctrl_o,
  output logic ram_valid_flag_o,
  output logic direct_transfer_flag_o,
  output logic cpu_restart_o,
  output logic instr_nop_o,
  output logic irq_service_o
);
  lpms_mode_t mode;
  lpms_mode_t next_mode;
  lpms_mode_t wake_target;
  logic [`LPMS_CNT_W-1:0] wait_cnt;
  logic [`LPMS_CNT_W-1:0] next_wait;
  logic instr;
  logic blocked;
  lpms_gate_t next_gate;
  lpms_clk_t next_clk;

  assign instr = standby_instruction_i | stop_instruction_i;
  assign blocked = !global_interrupt_enable_i && irq_pending_i;

  // Mode transitions
  always_comb
  begin
    next_mode = mode;
    next_wait = '0;
    unique case (mode)
      LPMS_ACTIVE:
      begin
        if (stop_instruction_i && !blocked)
          next_mode = watch_select_bit_i ? LPMS_WATCH : LPMS_STOP;
        else if (standby_instruction_i && !blocked)
          next_mode = LPMS_STANDBY;
      end
      LPMS_STANDBY:
      begin
        if (irq_pending_i)
          next_mode = LPMS_ACTIVE;
      end
      LPMS_STOP:
      begin
        if (stop_cancel_pin_i)
          next_mode = LPMS_ACTIVE;
      end
      LPMS_WATCH:
      begin
        if (timer_a_irq_i || external_interrupt_zero_i)
        begin
          if (low_speed_flag_i && SUBACTIVE_EN)
            next_mode = LPMS_SUBACTIVE;
          else
          begin
            next_mode = LPMS_WAKE;
            next_wait = external_interrupt_zero_i ?
              `LPMS_CNT_W'(FRAME_CYCLES + STAB_CYCLES) : `LPMS_CNT_W'(STAB_CYCLES - 1);
          end
        end
      end
      LPMS_SUBACTIVE:
      begin
        if (instr && !blocked)
        begin
          if (direct_transfer_flag_o && !low_speed_flag_i)
          begin
            next_mode = LPMS_WAKE;
            next_wait = `LPMS_CNT_W'(STAB_CYCLES - 1);
          end
          else
            next_mode = LPMS_WATCH;
        end
      end
      LPMS_WAKE:
      begin
        next_wait = wait_cnt - `LPMS_CNT_W'(1);
        if (wait_cnt == '0)
          next_mode = LPMS_ACTIVE;
      end
      default:
        next_mode = LPMS_ACTIVE;
    endcase
  end

  always_ff @(posedge core_clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      mode <= LPMS_ACTIVE;
      wait_cnt <= '0;
    end
    else
    begin
      mode <= next_mode;
      wait_cnt <= next_wait;
    end
  end
  assign mode_o = mode;

  // Gating vector derived from the next mode so it changes with the mode
  always_comb
  begin
    next_gate = '{default: `LPMS_GATE_RUN};
    next_clk = '{main_osc_en: 1'b1, sub_osc_en: 1'b1, ports_hiz: 1'b0,
                 ports_hold: 1'b0, serial_irq_en: 1'b1};
    unique case (next_mode)
      LPMS_ACTIVE:
        next_clk = next_clk;
      LPMS_STANDBY:
      begin
        next_gate.cpu = `LPMS_GATE_STOP;
        next_gate.tone = `LPMS_GATE_STOP;
        next_clk.ports_hold = 1'b1;
      end
      LPMS_STOP:
      begin
        next_gate = '{default: `LPMS_GATE_RESET};
        next_clk.main_osc_en = 1'b0;
        next_clk.sub_osc_en = !subclock_stop_bit_i;
        next_clk.ports_hiz = 1'b1;
        next_clk.serial_irq_en = 1'b0;
      end
      LPMS_WATCH, LPMS_WAKE:
      begin
        next_gate.cpu = `LPMS_GATE_STOP;
        next_gate.timer_bcd = `LPMS_GATE_STOP;
        next_gate.serial = `LPMS_GATE_STOP;
        next_gate.adc = `LPMS_GATE_STOP;
        next_gate.tone = `LPMS_GATE_RESET;
        next_clk.main_osc_en = (next_mode == LPMS_WAKE);
        next_clk.ports_hold = 1'b1;
        next_clk.serial_irq_en = 1'b0;
      end
      LPMS_SUBACTIVE:
      begin
        next_gate.adc = `LPMS_GATE_STOP;
        next_gate.tone = `LPMS_GATE_RESET;
        next_clk.main_osc_en = 1'b0;
      end
      default:
        next_clk = next_clk;
    endcase
  end

  always_ff @(posedge core_clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      gate_o <= '{default: `LPMS_GATE_RUN};
      clk_ctrl_o <= '{main_osc_en: 1'b1, sub_osc_en: 1'b1, ports_hiz: 1'b0,
                      ports_hold: 1'b0, serial_irq_en: 1'b1};
    end
    else
    begin
      gate_o <= next_gate;
      clk_ctrl_o <= next_clk;
    end
  end

  // RAM valid flag
  always_ff @(posedge core_clk_i or posedge reset_i)
  begin
    if (reset_i)
      ram_valid_flag_o <= `LPMS_RAM_VALID_RST;
    else if (mode == LPMS_STOP && stop_cancel_pin_i)
      ram_valid_flag_o <= 1'b1;
  end

  // Direct transfer flag
  always_ff @(posedge core_clk_i or posedge reset_i)
  begin
    if (reset_i)
      direct_transfer_flag_o <= 1'b0;
    else if (mode == LPMS_ACTIVE)
      direct_transfer_flag_o <= 1'b0;
    else if (mode == LPMS_SUBACTIVE && direct_transfer_set_i)
      direct_transfer_flag_o <= 1'b1;
  end

  // CPU strobes
  always_ff @(posedge core_clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      cpu_restart_o <= 1'b0;
      instr_nop_o <= 1'b0;
      irq_service_o <= 1'b0;
    end
    else
    begin
      cpu_restart_o <= (mode == LPMS_STOP) && stop_cancel_pin_i;
      instr_nop_o <= instr && blocked &&
                     (mode == LPMS_ACTIVE || mode == LPMS_SUBACTIVE);
      irq_service_o <= (mode == LPMS_STANDBY) && irq_pending_i &&
                       global_interrupt_enable_i;
    end
  end

  // Assertions
  sequence s_wake_start;
    mode == LPMS_WATCH && timer_a_irq_i && !external_interrupt_zero_i && !low_speed_flag_i;
  endsequence
  AST_STANDBY_ENTRY: assert property (@(posedge core_clk_i) disable iff (reset_i)
    mode == LPMS_ACTIVE && standby_instruction_i && !stop_instruction_i && !blocked
    |=> mode == LPMS_STANDBY)
    else $error("standby not entered");
  AST_STOP_SELECT: assert property (@(posedge core_clk_i) disable iff (reset_i)
    mode == LPMS_ACTIVE && stop_instruction_i && !blocked
    |=> mode == (watch_select_bit_i ? LPMS_WATCH : LPMS_STOP) ##1 !clk_ctrl_o.main_osc_en)
    else $error("stop selection wrong");
  AST_STOP_HIZ: assert property (@(posedge core_clk_i) disable iff (reset_i)
    mode == LPMS_STOP |=> clk_ctrl_o.ports_hiz || $past(stop_cancel_pin_i))
    else $error("ports not high impedance in stop");
  AST_NOP: assert property (@(posedge core_clk_i) disable iff (reset_i)
    mode == LPMS_ACTIVE && instr && blocked |=> mode == LPMS_ACTIVE && instr_nop_o)
    else $error("blocked instruction not a no-op");
  AST_RAM_VALID: assert property (@(posedge core_clk_i) disable iff (reset_i)
    mode == LPMS_STOP && stop_cancel_pin_i |=> ram_valid_flag_o && mode == LPMS_ACTIVE)
    else $error("ram valid flag not set");
  AST_DIRECT_CLEAR: assert property (@(posedge core_clk_i) disable iff (reset_i)
    mode == LPMS_ACTIVE |=> !direct_transfer_flag_o)
    else $error("direct flag held in active");
  AST_STANDBY_WAKE: assert property (@(posedge core_clk_i) disable iff (reset_i)
    mode == LPMS_STANDBY && irq_pending_i |=> mode == LPMS_ACTIVE)
    else $error("standby did not wake");
  AST_WATCH_SERIAL: assert property (@(posedge core_clk_i) disable iff (reset_i)
    mode == LPMS_WATCH |-> !clk_ctrl_o.serial_irq_en)
    else $error("serial irq enabled in watch");
  AST_TIMER_WAKE: assert property (@(posedge core_clk_i) disable iff (reset_i)
    s_wake_start |=> mode == LPMS_WAKE)
    else $error("watch wake not started");

  sequence s_ext_start;
    mode == LPMS_WATCH && external_interrupt_zero_i && !low_speed_flag_i;
  endsequence

  AST_EXT_WAKE: assert property (@(posedge core_clk_i) disable iff (reset_i)
    s_ext_start |=> mode == LPMS_WAKE && wait_cnt == `LPMS_CNT_W'(FRAME_CYCLES + STAB_CYCLES))
    else $error("external wake delay not loaded");

  AST_ACTIVE_CLOCKS: assert property (@(posedge core_clk_i) disable iff (reset_i)
    mode == LPMS_ACTIVE |-> clk_ctrl_o.main_osc_en && gate_o.cpu == `LPMS_GATE_RUN)
    else $error("active mode not on main oscillator");

  AST_STANDBY_OSC: assert property (@(posedge core_clk_i) disable iff (reset_i)
    mode == LPMS_STANDBY |-> clk_ctrl_o.main_osc_en && clk_ctrl_o.sub_osc_en)
    else $error("oscillator stopped in standby");

  AST_PORT_HOLD: assert property (@(posedge core_clk_i) disable iff (reset_i)
    mode == LPMS_STANDBY || mode == LPMS_WATCH |-> clk_ctrl_o.ports_hold)
    else $error("ports not held");

  AST_IRQ_SERVICE: assert property (@(posedge core_clk_i) disable iff (reset_i)
    mode == LPMS_STANDBY && irq_pending_i && global_interrupt_enable_i |=> irq_service_o)
    else $error("interrupt not serviced after wake");

  AST_STOP_SUBCLK: assert property (@(posedge core_clk_i) disable iff (reset_i)
    mode == LPMS_STOP |-> clk_ctrl_o.sub_osc_en == !$past(subclock_stop_bit_i))
    else $error("sub oscillator wrong in stop");

  AST_STOP_STAY: assert property (@(posedge core_clk_i) disable iff (reset_i)
    mode == LPMS_STOP && !stop_cancel_pin_i |=> mode == LPMS_STOP)
    else $error("stop left without cancel");

  AST_RESTART: assert property (@(posedge core_clk_i) disable iff (reset_i)
    mode == LPMS_STOP && stop_cancel_pin_i |=> cpu_restart_o)
    else $error("no restart after cancel");

  AST_STOP_GATES: assert property (@(posedge core_clk_i) disable iff (reset_i)
    mode == LPMS_STOP |-> gate_o.cpu == `LPMS_GATE_RESET && gate_o.serial == `LPMS_GATE_RESET)
    else $error("peripherals not reset in stop");

  AST_RAM_KEEP: assert property (@(posedge core_clk_i) disable iff (reset_i)
    ram_valid_flag_o |=> ram_valid_flag_o)
    else $error("ram valid flag lost");

  AST_WATCH_GATES: assert property (@(posedge core_clk_i) disable iff (reset_i)
    mode == LPMS_WATCH |-> !clk_ctrl_o.main_osc_en && gate_o.timer_a == `LPMS_GATE_RUN &&
    gate_o.lcd == `LPMS_GATE_RUN && gate_o.tone == `LPMS_GATE_RESET)
    else $error("watch gating wrong");

  AST_WATCH_TO_SUB: assert property (@(posedge core_clk_i) disable iff (reset_i)
    mode == LPMS_WATCH && (timer_a_irq_i || external_interrupt_zero_i) && low_speed_flag_i &&
    SUBACTIVE_EN |=> mode == LPMS_SUBACTIVE)
    else $error("watch did not go subactive");

  AST_SUB_CLOCKS: assert property (@(posedge core_clk_i) disable iff (reset_i)
    mode == LPMS_SUBACTIVE |-> !clk_ctrl_o.main_osc_en && clk_ctrl_o.sub_osc_en &&
    gate_o.adc == `LPMS_GATE_STOP)
    else $error("subactive clocking wrong");

  AST_SUB_STAY: assert property (@(posedge core_clk_i) disable iff (reset_i)
    mode == LPMS_SUBACTIVE && !instr |=> mode == LPMS_SUBACTIVE)
    else $error("subactive left without instruction");

  AST_DIRECT_MOVE: assert property (@(posedge core_clk_i) disable iff (reset_i)
    mode == LPMS_SUBACTIVE && instr && !blocked && direct_transfer_flag_o &&
    !low_speed_flag_i |=> mode == LPMS_WAKE)
    else $error("direct transfer not taken");

  AST_CANCEL_IGNORED: assert property (@(posedge core_clk_i) disable iff (reset_i)
    mode != LPMS_STOP |=> $stable(ram_valid_flag_o))
    else $error("ram flag changed outside stop");

  AST_WAKE_GATES: assert property (@(posedge core_clk_i) disable iff (reset_i)
    mode == LPMS_WAKE |-> gate_o.cpu == `LPMS_GATE_STOP && clk_ctrl_o.main_osc_en)
    else $error("wake gating wrong");
endmodule

//--- lpms_regs.svh
// Constants of the low-power mode sequencer: timing counts and reset values
// Assumes a 200 MHz core clock; included by the package user files
`ifndef LPMS_REGS_SVH
`define LPMS_REGS_SVH
`define LPMS_CLK_PERIOD_NS 5
`define LPMS_STAB_TIME_US 1000
`define LPMS_STAB_CYCLES ((`LPMS_STAB_TIME_US * 1000) / `LPMS_CLK_PERIOD_NS)
`define LPMS_FRAME_TIME_US 7812
`define LPMS_FRAME_CYCLES ((`LPMS_FRAME_TIME_US * 1000) / `LPMS_CLK_PERIOD_NS)
`define LPMS_CNT_W 24
`define LPMS_RAM_VALID_RST 1'h0
`define LPMS_GATE_RUN 2'h0
`define LPMS_GATE_STOP 2'h1
`define LPMS_GATE_RESET 2'h2
`endif

//--- lpms_pkg.sv
// Types of the low-power mode sequencer
// Assumes lpms_regs.svh is included alongside
package lpms_pkg;
  typedef enum logic [2:0] {
    LPMS_ACTIVE,
    LPMS_STANDBY,
    LPMS_STOP,
    LPMS_WATCH,
    LPMS_SUBACTIVE,
    LPMS_WAKE
  } lpms_mode_t;
  typedef struct packed {
    logic [1:0] cpu;
    logic [1:0] timer_a;
    logic [1:0] timer_bcd;
    logic [1:0] serial;
    logic [1:0] adc;
    logic [1:0] lcd;
    logic [1:0] tone;
  } lpms_gate_t;
  typedef struct packed {
    logic main_osc_en;
    logic sub_osc_en;
    logic ports_hiz;
    logic ports_hold;
    logic serial_irq_en;
  } lpms_clk_t;
endpackage

//--- lpms_cpu_model.sv
// Model of the CPU core and interrupt sources that face the mode sequencer
// Assumes the bench calls its tasks; requests change 1 ns after a rising edge
`timescale 1ns/10ps
module lpms_cpu_model
(
  input wire logic clk_i,
  output logic [4:0] req_o,
  output logic cancel_o
);
  initial
  begin
    req_o = '0;
    cancel_o = 1'b0;
  end
  // Pulse: 0 standby, 1 stop, 2 direct set, 3 timer A, 4 ext irq zero
  task pulse(input int i);
    @(posedge clk_i);
    #1 req_o[i] = 1'b1;
    @(posedge clk_i);
    #1 req_o[i] = 1'b0;
  endtask
  // Cancel held for n clock cycles
  task hold_cancel(input int n);
    @(posedge clk_i);
    #1 cancel_o = 1'b1;
    repeat (n) @(posedge clk_i);
    #1 cancel_o = 1'b0;
  endtask
endmodule

//--- low_power_mode_sequencer_tb.sv
// Self-checking bench of the mode sequencer
// Assumes lpms_pkg and lpms_regs.svh; short stabilisation and frame counts
`timescale 1ns/10ps
`include "lpms_regs.svh"
module low_power_mode_sequencer_tb;
  import lpms_pkg::*;
  localparam int STAB = 4;
  localparam int FRAME = 10;
  logic core_clk_i = 0;
  logic reset_i = 1;
  logic wsel = 0, sstop = 0, lspd = 0, gie = 1, pend = 0;
  logic [4:0] req;
  logic cancel;
  lpms_mode_t mode;
  lpms_gate_t gate;
  lpms_clk_t cc;
  logic ram_v, dtf, nop_p, svc_p, rst_p;
  bit rs_seen = 0;
  int n_mismatch = 0;
  int n_tests = 0;
  int n;
  bit nop_seen = 0, svc_seen = 0;
  always #2.5 core_clk_i = ~core_clk_i;
  always @(posedge core_clk_i)
  begin
    if (nop_p === 1'b1) nop_seen <= 1;
    if (svc_p === 1'b1) svc_seen <= 1;
    if (rst_p === 1'b1) rs_seen <= 1;
  end
  lpms_sequencer #(.STAB_CYCLES(STAB), .FRAME_CYCLES(FRAME)) u_lpms_sequencer (
    .core_clk_i(core_clk_i), .reset_i(reset_i),
    .standby_instruction_i(req[0]), .stop_instruction_i(req[1]),
    .watch_select_bit_i(wsel), .subclock_stop_bit_i(sstop),
    .low_speed_flag_i(lspd), .direct_transfer_set_i(req[2]),
    .global_interrupt_enable_i(gie), .irq_pending_i(pend),
    .timer_a_irq_i(req[3]), .external_interrupt_zero_i(req[4]),
    .stop_cancel_pin_i(cancel), .mode_o(mode), .gate_o(gate), .clk_ctrl_o(cc),
    .ram_valid_flag_o(ram_v), .direct_transfer_flag_o(dtf), .cpu_restart_o(rst_p),
    .instr_nop_o(nop_p), .irq_service_o(svc_p));
  lpms_cpu_model u_lpms_cpu_model (.clk_i(core_clk_i), .req_o(req), .cancel_o(cancel));
  task chk(input bit ok, input string m);
    n_tests++;
    if (!ok)
    begin
      $display("wrong value at %0t: %s", $time, m);
      n_mismatch++;
    end
  endtask
  task chm(input lpms_mode_t e);
    chk(mode === e, "mode");
  endtask
  task wake(input int lo, input int hi);
    n = 0;
    while (mode !== LPMS_ACTIVE && n < 100)
    begin
      @(posedge core_clk_i);
      #1 n++;
    end
    chk(n >= lo && n <= hi, "wake delay");
  endtask
  task complete_run;
    $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  initial
  begin
    #20000;
    n_mismatch++;
    complete_run;
  end
  initial
  begin
    void'($urandom(32'hbb47363d));
    repeat (3) @(posedge core_clk_i);
    #1 reset_i = 0;
    chm(LPMS_ACTIVE);
    chk(cc.main_osc_en === 1'b1 && gate === '0 && ram_v === 1'b0, "reset");
    u_lpms_cpu_model.pulse(2);
    chk(dtf === 1'b0, "direct set in active");
    $display("test reset done");
    u_lpms_cpu_model.pulse(0);
    chm(LPMS_STANDBY);
    chk(cc.ports_hold === 1'b1 && cc.sub_osc_en === 1'b1 && cc.main_osc_en === 1'b1, "sby");
    #1 pend = 1;
    @(posedge core_clk_i);
    #1 pend = 0;
    chm(LPMS_ACTIVE);
    @(posedge core_clk_i);
    #1 chk(svc_seen, "service");
    $display("test standby done");
    for (int k = 0; k < 2; k++)
    begin
      sstop = $urandom % 2;
      u_lpms_cpu_model.pulse(1);
      chm(LPMS_STOP);
      chk(cc.main_osc_en === 1'b0 && cc.sub_osc_en === ~sstop, "osc");
      chk(cc.ports_hiz === 1'b1 && gate.cpu === `LPMS_GATE_RESET, "stop gates");
      u_lpms_cpu_model.hold_cancel(STAB);
      chm(LPMS_ACTIVE);
      chk(ram_v === 1'b1, "ram flag set");
    end
    chk(rs_seen, "restart");
    u_lpms_cpu_model.hold_cancel(2);
    chm(LPMS_ACTIVE);
    chk(ram_v === 1'b1, "ram flag kept");
    u_lpms_cpu_model.pulse(1);
    reset_i = 1;
    @(posedge core_clk_i);
    #1 reset_i = 0;
    chk(mode === LPMS_ACTIVE && ram_v === 1'b0, "reset from stop");
    $display("test stop done");
    gie = 0;
    pend = 1;
    u_lpms_cpu_model.pulse(0);
    u_lpms_cpu_model.pulse(1);
    chm(LPMS_ACTIVE);
    chk(nop_seen, "nop");
    pend = 0;
    gie = 1;
    wsel = 1;
    for (int s = 3; s < 5; s++)
    begin
      u_lpms_cpu_model.pulse(1);
      chm(LPMS_WATCH);
      chk(gate.timer_a === `LPMS_GATE_RUN && gate.tone === `LPMS_GATE_RESET, "watch");
      chk(cc.serial_irq_en === 1'b0 && cc.main_osc_en === 1'b0, "watch irq");
      u_lpms_cpu_model.pulse(s);
      chm(LPMS_WAKE);
      if (s == 3)
        wake(STAB, STAB + 1);
      else
        wake(FRAME + STAB, 2 * FRAME + STAB - 2);
    end
    $display("test watch done");
    lspd = 1;
    u_lpms_cpu_model.pulse(1);
    u_lpms_cpu_model.pulse(3);
    chm(LPMS_SUBACTIVE);
    chk(gate.adc === `LPMS_GATE_STOP && cc.main_osc_en === 1'b0, "sub");
    u_lpms_cpu_model.pulse(0);
    chm(LPMS_WATCH);
    u_lpms_cpu_model.pulse(4);
    lspd = 0;
    u_lpms_cpu_model.pulse(2);
    chk(dtf === 1'b1, "direct flag");
    u_lpms_cpu_model.pulse(1);
    chm(LPMS_WAKE);
    wake(STAB, STAB + 1);
    @(posedge core_clk_i);
    #1 chk(dtf === 1'b0, "direct clear");
    $display("test subactive done");
    complete_run;
  end
endmodule
